// [common/trmc_params.svh]
// Timing counts, widths and bit positions for the tag reader mode control.
`ifndef TRMC_PARAMS_SVH
`define TRMC_PARAMS_SVH
`define TRMC_XTAL_PERIOD_NS 125
`define TRMC_CLK_PERIOD_NS 40
`define TRMC_RW_TOGGLE_TIME_XTAL_PERIOD 8064
`define TRMC_RW_TOGGLE_EARLY_XTAL_PERIOD 7932
`define TRMC_STANDBY_HOLD_TIME_XTAL_PERIOD 16256
`define TRMC_STANDBY_HOLD_EARLY_XTAL_PERIOD 16128
`define TRMC_WAKE_XTAL_PERIOD 4096
`define TRMC_ACK_NS 100000
`define TRMC_DN(t) (((t) * `TRMC_XTAL_PERIOD_NS) / `TRMC_CLK_PERIOD_NS)
`define TRMC_UP(t) (((t) * `TRMC_XTAL_PERIOD_NS + `TRMC_CLK_PERIOD_NS - 1) / `TRMC_CLK_PERIOD_NS)
`define TRMC_RW_CYC `TRMC_DN(`TRMC_RW_TOGGLE_TIME_XTAL_PERIOD)
`define TRMC_RW_EARLY_CYC `TRMC_UP(`TRMC_RW_TOGGLE_EARLY_XTAL_PERIOD)
`define TRMC_SB_CYC `TRMC_DN(`TRMC_STANDBY_HOLD_TIME_XTAL_PERIOD)
`define TRMC_SB_EARLY_CYC `TRMC_UP(`TRMC_STANDBY_HOLD_EARLY_XTAL_PERIOD)
`define TRMC_WAKE_CYC `TRMC_DN(`TRMC_WAKE_XTAL_PERIOD)
`define TRMC_ACK_CYC (`TRMC_ACK_NS / `TRMC_CLK_PERIOD_NS)
`define TRMC_CNT_W 16
`define TRMC_CNT_ZERO 16'h0000
`define TRMC_CNT_ONE 16'h0001
`define TRMC_CNT_MAX 16'hffff
`define TRMC_SETTLE_CYC 16'h0008
`define TRMC_IN_N 5
`define TRMC_IN_HI 4
`define TRMC_IN_LO 3
`define TRMC_IN_MOD 2
`define TRMC_IN_LINE 1
`define TRMC_IN_TX 0
`endif

// [common/trmc_pkg.sv]
// Types of the tag reader mode control.
package trmc_pkg;
   typedef enum logic [1:0] {
      CFG_A = 2'h0,
      CFG_B = 2'h1,
      CFG_C = 2'h2
   } trmc_cfg_t;
   typedef enum logic [2:0] {
      ST_READ = 3'h0,
      ST_WRITE = 3'h1,
      ST_HOLD = 3'h3,
      ST_ACK = 3'h2,
      ST_STBY = 3'h6,
      ST_WAKE = 3'h7
   } trmc_state_t;
endpackage : trmc_pkg

// [core/trmc_core.sv]
// Mode control of the tag reader: strap decode, mode sequencing and pin routing.
`include "trmc_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Both straps low selects the one-wire bus configuration.
// - One-wire: start in read mode, tag data drives the line.
// - One-wire read: line held low past the toggle time enters write mode.
// - One-wire write: both antenna drivers follow the line level.
// - One-wire write: line idle high for the toggle time returns to read.
// - One-wire write: line low past the hold time requests standby.
// - After the line is released, one acknowledge pulse, then standby.
// - One-wire standby: oscillator off, drive a low, drive b high.
// - One-wire standby: rising line wakes; read mode after wake-up.
// - One-wire: direct data and monitor low, transmit input ignored.
// - Read/write toggle guaranteed at 8064 periods, allowed from 7932.
// - Standby hold guaranteed at 16256 periods, allowed from 16128.
// - Two-wire: modulation input drives antennas and shows on the line.
// - Two-wire: modulation low past hold time gives acknowledge, standby.
// - Two-wire standby: drive a low, drive b high.
// - Two-wire standby: rising modulation input wakes into read mode.
// - Two-wire: direct data and monitor low, transmit input ignored.
// - First strap high: direct mode, data and modulation on direct output.
// - Direct mode, second strap low: standby, drivers frozen, data low.
// - Direct mode: transmit high drives the line dominant, low releases.
// - Direct mode: monitor follows the line level, in standby too; standby ignores transmit and modulation.
// - Reset clears all state and switches both antenna drivers on.
////////////////////////////////////////////////////////////////////////////////
module trmc_core #(
   parameter logic [`TRMC_CNT_W-1:0] P_RW_CYC = `TRMC_CNT_W'(`TRMC_RW_CYC),
   parameter logic [`TRMC_CNT_W-1:0] P_RW_EARLY = `TRMC_CNT_W'(`TRMC_RW_EARLY_CYC),
   parameter logic [`TRMC_CNT_W-1:0] P_SB_CYC = `TRMC_CNT_W'(`TRMC_SB_CYC),
   parameter logic [`TRMC_CNT_W-1:0] P_SB_EARLY = `TRMC_CNT_W'(`TRMC_SB_EARLY_CYC),
   parameter logic [`TRMC_CNT_W-1:0] P_WAKE_CYC = `TRMC_CNT_W'(`TRMC_WAKE_CYC)
) (
   input logic i_clk,
   input logic i_rst_n,
   input logic i_config_strap_hi,
   input logic i_config_strap_lo,
   input logic i_modulation_in,
   input logic i_line_rx,
   input logic i_line_tx,
   input logic i_demod_data,
   output logic o_line_out,
   output logic o_line_oe,
   output logic o_antenna_drive_a,
   output logic o_antenna_drive_b,
   output logic o_direct_data,
   output logic o_line_monitor,
   output logic o_osc_enable,
   output trmc_pkg::trmc_state_t o_state,
   output trmc_pkg::trmc_cfg_t o_config
);
   import trmc_pkg::*;

   localparam logic [`TRMC_CNT_W-1:0] ACK_CYC = `TRMC_CNT_W'(`TRMC_ACK_CYC);

   function automatic trmc_cfg_t trmc_cfg_of(input logic hi, input logic lo);
      if (hi) begin
         return CFG_C;
      end
      return lo ? CFG_B : CFG_A;
   endfunction : trmc_cfg_of

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers; a level is taken once the last two stages agree.
   logic [`TRMC_IN_N-1:0] raw;
   logic [`TRMC_IN_N-1:0] s1_reg;
   logic [`TRMC_IN_N-1:0] s2_reg;
   logic [`TRMC_IN_N-1:0] s3_reg;
   logic [`TRMC_IN_N-1:0] f_reg;

   assign raw = {i_config_strap_hi, i_config_strap_lo, i_modulation_in, i_line_rx, i_line_tx};

   genvar gi;
   generate
      for (gi = 0; gi < `TRMC_IN_N; gi++) begin : g_sync
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               s1_reg[gi] <= 1'h0;
               s2_reg[gi] <= 1'h0;
               s3_reg[gi] <= 1'h0;
               f_reg[gi] <= 1'h0;
            end else begin
               s1_reg[gi] <= raw[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               if (s2_reg[gi] == s3_reg[gi]) begin
                  f_reg[gi] <= s3_reg[gi];
               end
            end
         end
      end
   endgenerate

   logic lo_f;
   logic mod_f;
   logic line_f;
   logic tx_f;
   logic w_f;
   trmc_cfg_t cfg_now;

   assign lo_f = f_reg[`TRMC_IN_LO];
   assign mod_f = f_reg[`TRMC_IN_MOD];
   assign line_f = f_reg[`TRMC_IN_LINE];
   assign tx_f = f_reg[`TRMC_IN_TX];
   assign cfg_now = trmc_cfg_of(f_reg[`TRMC_IN_HI], lo_f);
   assign w_f = (cfg_now == CFG_A) ? line_f : mod_f;

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencer.
   trmc_state_t state_reg;
   trmc_state_t state_next;
   trmc_cfg_t cfg_reg;
   logic w_prev_reg;
   logic [`TRMC_CNT_W-1:0] run_cnt;
   logic [`TRMC_CNT_W-1:0] tmr_reg;
   logic st_chg;

   assign st_chg = (state_next != state_reg);

   always_comb begin
      state_next = state_reg;
      if (cfg_now != cfg_reg || cfg_now == CFG_C) begin
         state_next = ST_READ;
      end else begin
         case (state_reg)
            ST_READ: begin
               if (cfg_now == CFG_A && !w_f && run_cnt >= P_RW_CYC) begin
                  state_next = ST_WRITE;
               end else if (cfg_now == CFG_B && !w_f && run_cnt >= P_SB_CYC) begin
                  state_next = ST_ACK;
               end
            end
            ST_WRITE: begin
               if (w_f && run_cnt >= P_RW_CYC) begin
                  state_next = ST_READ;
               end else if (!w_f && run_cnt >= P_SB_CYC) begin
                  state_next = ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (w_f) begin
                  state_next = ST_ACK;
               end
            end
            ST_ACK: begin
               if (tmr_reg >= ACK_CYC) begin
                  state_next = ST_STBY;
               end
            end
            ST_STBY: begin
               if (w_f && !w_prev_reg && tmr_reg >= `TRMC_SETTLE_CYC) begin
                  state_next = ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (tmr_reg >= P_WAKE_CYC) begin
                  state_next = ST_READ;
               end
            end
            default: begin
               state_next = ST_READ;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= ST_READ;
         cfg_reg <= CFG_A;
      end else begin
         state_reg <= state_next;
         cfg_reg <= cfg_now;
      end
   end

   // Time the watched level since its last change or the last mode change.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         w_prev_reg <= 1'h0;
         run_cnt <= `TRMC_CNT_ZERO;
      end else begin
         w_prev_reg <= w_f;
         if (w_f != w_prev_reg || st_chg) begin
            run_cnt <= `TRMC_CNT_ZERO;
         end else if (run_cnt != `TRMC_CNT_MAX) begin
            run_cnt <= run_cnt + `TRMC_CNT_ONE;
         end
      end
   end

   // Time spent in the current mode, for acknowledge and wake-up.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tmr_reg <= `TRMC_CNT_ZERO;
      end else if (st_chg) begin
         tmr_reg <= `TRMC_CNT_ZERO;
      end else if (tmr_reg != `TRMC_CNT_MAX) begin
         tmr_reg <= tmr_reg + `TRMC_CNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Antenna drivers.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_antenna_drive_a <= 1'h1;
         o_antenna_drive_b <= 1'h1;
      end else if (cfg_now == CFG_C) begin
         if (lo_f) begin
            o_antenna_drive_a <= mod_f;
            o_antenna_drive_b <= mod_f;
         end
      end else begin
         case (state_next)
            ST_WRITE, ST_HOLD: begin
               o_antenna_drive_a <= w_f;
               o_antenna_drive_b <= w_f;
            end
            ST_READ: begin
               o_antenna_drive_a <= (cfg_now == CFG_B) ? w_f : 1'h1;
               o_antenna_drive_b <= (cfg_now == CFG_B) ? w_f : 1'h1;
            end
            ST_STBY: begin
               o_antenna_drive_a <= 1'h0;
               o_antenna_drive_b <= 1'h1;
            end
            ST_ACK: begin
               o_antenna_drive_a <= o_antenna_drive_a;
               o_antenna_drive_b <= o_antenna_drive_b;
            end
            default: begin
               o_antenna_drive_a <= 1'h1;
               o_antenna_drive_b <= 1'h1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Diagnostic line driver, open drain: enable high pulls the line low.
   assign o_line_out = 1'h0;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_line_oe <= 1'h0;
      end else if (cfg_now == CFG_C) begin
         o_line_oe <= lo_f & tx_f;
      end else begin
         case (state_next)
            ST_READ: begin
               if (cfg_now == CFG_A) begin
                  o_line_oe <= !i_demod_data;
               end else begin
                  o_line_oe <= !(i_demod_data & mod_f);
               end
            end
            ST_ACK: begin
               o_line_oe <= 1'h1;
            end
            default: begin
               o_line_oe <= 1'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Direct data, line monitor and oscillator enable.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_direct_data <= 1'h0;
         o_line_monitor <= 1'h0;
         o_osc_enable <= 1'h1;
      end else if (cfg_now == CFG_C) begin
         o_direct_data <= lo_f & i_demod_data & mod_f;
         o_line_monitor <= line_f;
         o_osc_enable <= lo_f;
      end else begin
         o_direct_data <= 1'h0;
         o_line_monitor <= 1'h0;
         o_osc_enable <= (state_next != ST_STBY);
      end
   end

   assign o_state = state_reg;
   assign o_config = cfg_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_BUS_QUIET: assert property (cfg_reg != CFG_C |-> !o_direct_data && !o_line_monitor)
      else $error("direct or monitor output active on a bus configuration");
   AST_STBY_DRV: assert property (cfg_reg != CFG_C && state_reg == ST_STBY
      |-> !o_antenna_drive_a && o_antenna_drive_b && !o_osc_enable && !o_line_oe)
      else $error("standby levels wrong");
   AST_TO_WRITE: assert property (cfg_reg == CFG_A && $past(state_reg) == ST_READ && state_reg == ST_WRITE
      |-> $past(run_cnt) >= P_RW_EARLY && !$past(line_f))
      else $error("write entered too early");
   AST_READ_TIMEOUT: assert property (cfg_reg == CFG_A && cfg_now == CFG_A && state_reg == ST_READ
      && !line_f && run_cnt >= P_RW_CYC |=> state_reg == ST_WRITE)
      else $error("write not entered at toggle time");
   AST_WRITE_FOLLOW: assert property (cfg_reg == CFG_A && state_reg == ST_WRITE
      |-> o_antenna_drive_a == $past(line_f) && o_antenna_drive_b == o_antenna_drive_a)
      else $error("antenna drivers do not follow the line");
   AST_HOLD_TIME: assert property ($past(state_reg) == ST_WRITE && state_reg == ST_HOLD
      |-> $past(run_cnt) >= P_SB_EARLY)
      else $error("standby hold accepted too early");
   AST_ACK_PULSE: assert property ($rose(state_reg == ST_ACK) |-> o_line_oe [*8])
      else $error("acknowledge pulse missing");
   AST_ACK_THEN_STBY: assert property ($past(state_reg) == ST_ACK && state_reg != ST_ACK
      && $stable(cfg_reg) |-> state_reg == ST_STBY)
      else $error("acknowledge not followed by standby");
   AST_WAKE: assert property (state_reg == ST_STBY && cfg_now == cfg_reg && w_f && !w_prev_reg
      && tmr_reg >= `TRMC_SETTLE_CYC |=> state_reg == ST_WAKE ##1 state_reg == ST_WAKE)
      else $error("rising edge did not wake");
   AST_C_TX: assert property (cfg_reg == CFG_C |-> o_line_oe == ($past(tx_f) && $past(lo_f)))
      else $error("line driver does not follow transmit input");
   AST_C_STBY: assert property (cfg_reg == CFG_C && $past(cfg_reg) == CFG_C && !$past(lo_f)
      |-> !o_direct_data && !o_osc_enable && $stable(o_antenna_drive_a) && $stable(o_antenna_drive_b))
      else $error("direct standby levels wrong");

   COV_WRITE: cover property (state_reg == ST_READ ##1 state_reg == ST_WRITE);
   COV_STBY: cover property (state_reg == ST_ACK ##1 state_reg == ST_STBY);
   COV_WAKE: cover property (state_reg == ST_WAKE ##1 state_reg == ST_READ);
   COV_C_STBY: cover property (cfg_reg == CFG_C && !o_osc_enable);
endmodule : trmc_core

// [verif/trmc_ecu_model.sv]
// Control unit model on the diagnostic line with an open-drain pull.
module trmc_ecu_model (
   input logic i_clk,
   input logic i_line_oe,
   input logic i_pull,
   output logic o_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull_reg;
   // The pull request is taken at the clock edge.
   always_ff @(posedge i_clk) begin
      pull_reg <= i_pull;
   end
   // A released wire rests at the pull-up level.
   assign o_line = !(i_line_oe || pull_reg);
endmodule : trmc_ecu_model

// [verif/trmc_tb_top.sv]
// Testbench of the tag reader mode control.
module trmc_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import trmc_pkg::*;
   localparam int RW = 40, RWE = 30, SB = 80, SBE = 70, WK = 20;
   logic clk = 1'b0, rst_n = 1'b0, hi = 1'b0, lo = 1'b0;
   logic mod = 1'b1, tx = 1'b0, demod = 1'b1, pull = 1'b0;
   logic line, oe, a, b, dd, mon, osc, lout;
   trmc_state_t st;
   trmc_cfg_t cf;
   int err_total = 0, n_checks = 0, cyc_cnt = 0;
   ////////////////////////////////////////////////////////////////////////////
   trmc_core #(.P_RW_CYC(16'h0028), .P_RW_EARLY(16'h001e), .P_SB_CYC(16'h0050),
      .P_SB_EARLY(16'h0046), .P_WAKE_CYC(16'h0014)) dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_config_strap_hi(hi), .i_config_strap_lo(lo),
      .i_modulation_in(mod), .i_line_rx(line), .i_line_tx(tx), .i_demod_data(demod),
      .o_line_out(lout), .o_line_oe(oe), .o_antenna_drive_a(a), .o_antenna_drive_b(b),
      .o_direct_data(dd), .o_line_monitor(mon), .o_osc_enable(osc), .o_state(st), .o_config(cf));
   trmc_ecu_model ecu (.i_clk(clk), .i_line_oe(oe), .i_pull(pull), .o_line(line));
   ////////////////////////////////////////////////////////////////////////////
   always #20 clk = !clk;
   always @(posedge clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic chk_bit(input logic g, input logic e, input string m);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask : chk_bit
   task automatic chk_st(input trmc_state_t e);
      n_checks++;
      if (st !== e) begin
         err_total++;
         $display("Error at %0t: state %0d not %0d", $time, st, e);
      end
   endtask : chk_st
   task automatic wait_st(input trmc_state_t e, input int lo_n, input int hi_n);
      int n;
      n = 0;
      while (st !== e && n < hi_n) begin
         cyc(1);
         n++;
      end
      chk_st(e);
      chk_bit(n >= lo_n, 1'b1, "state change too early");
   endtask : wait_st
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      cyc(5);
      chk_bit(a & b & osc, 1'b1, "reset drivers");
      chk_bit(oe | dd | mon, 1'b0, "reset outputs");
      @(posedge clk) rst_n <= 1'b1;
      cyc(10);
      $display("test reset done");
   endtask : t_reset
   task automatic t_a_rw();
      chk_bit(cf === CFG_A, 1'b1, "config a");
      @(posedge clk) demod <= 1'b0;
      cyc(2);
      chk_bit(oe, 1'b1, "data to line");
      @(posedge clk) begin demod <= 1'b1; tx <= 1'b1; end
      cyc(2);
      @(posedge clk) pull <= 1'b1;
      wait_st(ST_WRITE, RWE, RW + 10);
      chk_bit(a | b, 1'b0, "drivers off");
      @(posedge clk) pull <= 1'b0;
      cyc(8);
      chk_bit(a & b, 1'b1, "drivers on");
      wait_st(ST_READ, RWE - 8, RW + 10);
      chk_bit(oe | dd | mon, 1'b0, "a outputs");
      $display("test a write read done");
   endtask : t_a_rw
   task automatic t_a_sb();
      @(posedge clk) pull <= 1'b1;
      wait_st(ST_WRITE, RWE, RW + 10);
      wait_st(ST_HOLD, SBE, SB + 10);
      @(posedge clk) pull <= 1'b0;
      wait_st(ST_ACK, 0, 10);
      chk_bit(oe, 1'b1, "ack pulse");
      wait_st(ST_STBY, 2490, 2510);
      chk_bit(a | osc, 1'b0, "standby a");
      chk_bit(b, 1'b1, "standby b");
      cyc(20);
      @(posedge clk) pull <= 1'b1;
      cyc(10);
      chk_st(ST_STBY);
      @(posedge clk) pull <= 1'b0;
      wait_st(ST_WAKE, 0, 10);
      wait_st(ST_READ, WK, WK + 10);
      chk_bit(osc, 1'b1, "osc on");
      $display("test a standby done");
   endtask : t_a_sb
   task automatic t_b();
      @(posedge clk) lo <= 1'b1;
      cyc(10);
      chk_bit(cf === CFG_B, 1'b1, "config b");
      @(posedge clk) demod <= 1'b0;
      cyc(2);
      chk_bit(oe, 1'b1, "b data");
      @(posedge clk) demod <= 1'b1;
      @(posedge clk) mod <= 1'b0;
      cyc(8);
      chk_bit(a | b, 1'b0, "b drivers");
      chk_bit(oe, 1'b1, "b mod on line");
      wait_st(ST_ACK, SBE - 8, SB + 10);
      wait_st(ST_STBY, 2490, 2510);
      chk_bit(a, 1'b0, "b standby a");
      chk_bit(b, 1'b1, "b standby b");
      cyc(20);
      @(posedge clk) mod <= 1'b1;
      wait_st(ST_WAKE, 0, 10);
      wait_st(ST_READ, WK, WK + 10);
      chk_bit(dd | mon, 1'b0, "b outputs");
      $display("test b done");
   endtask : t_b
   task automatic t_c();
      @(posedge clk) hi <= 1'b1;
      cyc(10);
      chk_bit(cf === CFG_C, 1'b1, "config c");
      chk_bit(dd, 1'b1, "c data");
      chk_bit(oe, 1'b1, "tx drives");
      chk_bit(lout, 1'b0, "line driver level");
      chk_bit(mon, 1'b0, "monitor low");
      @(posedge clk) begin mod <= 1'b0; tx <= 1'b0; end
      cyc(12);
      chk_bit(dd | a, 1'b0, "c mod");
      chk_bit(oe, 1'b0, "tx off");
      chk_bit(mon, 1'b1, "monitor high");
      @(posedge clk) lo <= 1'b0;
      cyc(8);
      @(posedge clk) begin mod <= 1'b1; tx <= 1'b1; end
      cyc(8);
      chk_bit(a | dd, 1'b0, "c frozen");
      chk_bit(oe, 1'b0, "tx ignored");
      @(posedge clk) pull <= 1'b1;
      cyc(8);
      chk_bit(mon, 1'b0, "standby monitor");
      $display("test c done");
   endtask : t_c
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      t_reset();
      t_a_rw();
      t_a_sb();
      t_b();
      t_c();
      end_of_test();
   end
endmodule : trmc_tb_top
